// >>> src/clk_gen_pkg.sv
// Shared types and constants for the dual PLL clock generation control.
// Assumes a single 10 MHz system clock; PLL analog macros sit outside.
package clk_gen_pkg;

  // Core and secondary PLL divider settings
  typedef struct packed {
    logic [2:0]  output_divider;
    logic [12:0] fb_div;
    logic [5:0]  ref_div;
  } pll_cfg_t;

  // Fractional feedback control
  typedef struct packed {
    logic       en;
    logic [7:0] period;
    logic [7:0] fraction;
  } frac_cfg_t;

  // Boot values of the core PLL (multiply about 16.667)
  localparam logic [2:0]  CORE_OD_RST = 3'h2;
  localparam logic [12:0] CORE_FB_RST = 13'h0063;
  localparam logic [5:0]  CORE_REF_RST = 6'h00;
  localparam pll_cfg_t CORE_CFG_RST = '{CORE_OD_RST, CORE_FB_RST, CORE_REF_RST};

  // Secondary PLL idles with the same safe settings
  localparam pll_cfg_t PLL2_CFG_RST = '{CORE_OD_RST, CORE_FB_RST, CORE_REF_RST};
  localparam frac_cfg_t FRAC_CFG_RST = '{1'b0, 8'h00, 8'h00};

  // Soft reset pulse width
  localparam int SOFT_RST_NS = 1000;
  localparam int CLK_PERIOD_NS = 100;
  localparam int SOFT_RST_CYC = (SOFT_RST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] SOFT_RST_CNT = 4'(SOFT_RST_CYC);

  localparam logic [7:0] DIV_ZERO = 8'h00;

  // Cycles kept off the PLL so a stale synchronised lock is never trusted
  localparam logic [1:0] SETTLE_CNT = 2'h3;

  // Clock source switch
  typedef enum logic [1:0] {
    SW_PLL    = 2'b00,
    SW_OSC    = 2'b01,
    SW_RELOCK = 2'b10,
    SW_LOWPWR = 2'b11
  } sw_state_t;

endpackage

// >>> src/tick_div.sv
// Divides a stream of source ticks: one output pulse per (div_i + 1) ticks.
// Source ticks and the divider value live on the system clock.
`timescale 1ns/10ps
`default_nettype none
module tick_div (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // Source and setting
  input wire logic tick_i,
  input wire logic [7:0] div_i,
  // Divided tick
  output logic tick_o
);

  logic [7:0] cnt_r;
  logic [7:0] cnt_nxt;
  logic hit;

  // A shrinking setting never strands the count above the new limit
  assign hit = tick_i && (cnt_r >= div_i);
  assign tick_o = hit;

  always_comb begin
    cnt_nxt = cnt_r;
    if (hit) begin
      cnt_nxt = clk_gen_pkg::DIV_ZERO;
    end else if (tick_i) begin
      cnt_nxt = cnt_r + 8'h01;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt_r <= 8'h00;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

endmodule
`default_nettype wire

// >>> src/clk_gen_ctrl.sv
// Clock generation control: core PLL and secondary PLL settings, glitch-free
// source switching, derived clock enables, fractional feedback sequencing,
// application clock divider and the soft reset that spares the PLL state.
// Assumes the PLL macros take the settings and report lock asynchronously;
// PLL output ticks arrive as one-cycle pulses on the system clock.
`timescale 1ns/10ps
`default_nettype none

module clk_gen_ctrl (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // Core PLL configuration
  input wire logic core_cfg_wr_i,
  input wire clk_gen_pkg::pll_cfg_t core_cfg_i,
  // Secondary PLL configuration
  input wire logic pll2_cfg_wr_i,
  input wire clk_gen_pkg::pll_cfg_t pll2_cfg_i,
  input wire logic pll2_src_core_i,
  input wire clk_gen_pkg::frac_cfg_t frac_cfg_i,
  input wire logic app_en_i,
  input wire logic [7:0] app_div_i,
  // Clock dividers and power
  input wire logic [7:0] tile_div_i,
  input wire logic [7:0] switch_div_i,
  input wire logic [7:0] ref_div_i,
  input wire logic low_power_i,
  input wire logic soft_rst_req_i,
  // From the PLL macros
  input wire logic core_tick_i,
  input wire logic pll2_tick_i,
  input wire logic core_lock_i,
  input wire logic pll2_lock_i,
  // To the PLL macros
  output clk_gen_pkg::pll_cfg_t core_cfg_o,
  output clk_gen_pkg::pll_cfg_t pll2_cfg_o,
  output logic [12:0] pll2_fb_eff_o,
  output logic pll2_src_core_o,
  output logic pll_lowpower_o,
  // Derived clocks and status
  output logic tile_ce_o,
  output logic switch_ce_o,
  output logic ref_ce_o,
  output logic app_clock_out_pin_o,
  output logic tile1_clock_port_o,
  output logic on_pll_o,
  output logic soft_rstn_o
);

  logic rst_s1_r;
  logic rst_s2_r;
  logic rstn;

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rst_s1_r <= 1'b0;
      rst_s2_r <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_s2_r <= rst_s1_r;
    end
  end
  assign rstn = rst_s2_r;

  // Lock indications come from the analog side
  logic clock_s1_r;
  logic clock_s2_r;
  logic lock2_s1_r;
  logic lock2_s2_r;

  always_ff @(posedge clk_i or negedge rstn) begin
    if (!rstn) begin
      clock_s1_r <= 1'b0;
      clock_s2_r <= 1'b0;
      lock2_s1_r <= 1'b0;
      lock2_s2_r <= 1'b0;
    end else begin
      clock_s1_r <= core_lock_i;
      clock_s2_r <= clock_s1_r;
      lock2_s1_r <= pll2_lock_i;
      lock2_s2_r <= lock2_s1_r;
    end
  end

  // PLL settings: reset only by the power-on reset, never by soft reset
  clk_gen_pkg::pll_cfg_t core_cfg_r;
  clk_gen_pkg::pll_cfg_t core_cfg_nxt;
  clk_gen_pkg::pll_cfg_t pll2_cfg_r;
  clk_gen_pkg::pll_cfg_t pll2_cfg_nxt;
  clk_gen_pkg::frac_cfg_t frac_r;
  clk_gen_pkg::frac_cfg_t frac_nxt;
  logic src_core_r;
  logic src_core_nxt;

  always_comb begin
    core_cfg_nxt = core_cfg_r;
    pll2_cfg_nxt = pll2_cfg_r;
    frac_nxt = frac_r;
    src_core_nxt = src_core_r;
    if (core_cfg_wr_i) begin
      core_cfg_nxt = core_cfg_i;
    end
    if (pll2_cfg_wr_i) begin
      pll2_cfg_nxt = pll2_cfg_i;
      frac_nxt = frac_cfg_i;
      src_core_nxt = pll2_src_core_i;
    end
  end

  always_ff @(posedge clk_i or negedge rstn) begin
    if (!rstn) begin
      core_cfg_r <= clk_gen_pkg::CORE_CFG_RST;
      pll2_cfg_r <= clk_gen_pkg::PLL2_CFG_RST;
      frac_r <= clk_gen_pkg::FRAC_CFG_RST;
      src_core_r <= 1'b0;
    end else begin
      core_cfg_r <= core_cfg_nxt;
      pll2_cfg_r <= pll2_cfg_nxt;
      frac_r <= frac_nxt;
      src_core_r <= src_core_nxt;
    end
  end

  // The frequency itself is set by the macro from these fields
  assign core_cfg_o = core_cfg_r;
  assign pll2_cfg_o = pll2_cfg_r;
  assign pll2_src_core_o = src_core_r;

  // Source switch: consumers park on the oscillator while the PLL settles
  clk_gen_pkg::sw_state_t sw_r;
  clk_gen_pkg::sw_state_t sw_nxt;
  logic [1:0] settle_r;
  logic [1:0] settle_nxt;

  always_comb begin
    sw_nxt = sw_r;
    // Lock passes two flops, so wait that out before believing it again
    settle_nxt = (settle_r != 2'h0) ? settle_r - 2'h1 : settle_r;
    if (sw_r == clk_gen_pkg::SW_OSC || sw_r == clk_gen_pkg::SW_LOWPWR) begin
      settle_nxt = clk_gen_pkg::SETTLE_CNT;
    end
    case (sw_r)
      clk_gen_pkg::SW_PLL: begin
        if (low_power_i) begin
          sw_nxt = clk_gen_pkg::SW_LOWPWR;
        end else if (core_cfg_wr_i || !clock_s2_r) begin
          sw_nxt = clk_gen_pkg::SW_OSC;
        end
      end
      clk_gen_pkg::SW_OSC: begin
        sw_nxt = low_power_i ? clk_gen_pkg::SW_LOWPWR : clk_gen_pkg::SW_RELOCK;
      end
      clk_gen_pkg::SW_RELOCK: begin
        if (low_power_i) begin
          sw_nxt = clk_gen_pkg::SW_LOWPWR;
        end else if (core_cfg_wr_i) begin
          sw_nxt = clk_gen_pkg::SW_OSC;
        end else if (clock_s2_r && core_tick_i && (settle_r == 2'h0)) begin
          sw_nxt = clk_gen_pkg::SW_PLL;
        end
      end
      clk_gen_pkg::SW_LOWPWR: begin
        if (!low_power_i) begin
          sw_nxt = clk_gen_pkg::SW_RELOCK;
        end
      end
      default: begin
        sw_nxt = clk_gen_pkg::SW_OSC;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge rstn) begin
    if (!rstn) begin
      sw_r <= clk_gen_pkg::SW_RELOCK;
      settle_r <= clk_gen_pkg::SETTLE_CNT;
    end else begin
      sw_r <= sw_nxt;
      settle_r <= settle_nxt;
    end
  end

  logic on_pll;
  logic src_tick;
  assign on_pll = (sw_r == clk_gen_pkg::SW_PLL);
  assign pll_lowpower_o = (sw_r == clk_gen_pkg::SW_LOWPWR);
  assign on_pll_o = on_pll;
  // Off the PLL every system cycle stands for an oscillator tick
  assign src_tick = on_pll ? core_tick_i : 1'b1;

  // Tile and switch divide on their own; reference has its own divider
  tick_div u_tile_div (
    .clk_i(clk_i),
    .rstn_i(rstn),
    .tick_i(src_tick),
    .div_i(tile_div_i),
    .tick_o(tile_ce_o)
  );

  tick_div u_switch_div (
    .clk_i(clk_i),
    .rstn_i(rstn),
    .tick_i(src_tick),
    .div_i(switch_div_i),
    .tick_o(switch_ce_o)
  );

  tick_div u_ref_div (
    .clk_i(clk_i),
    .rstn_i(rstn),
    .tick_i(src_tick),
    .div_i(ref_div_i),
    .tick_o(ref_ce_o)
  );

  // Fractional sequencing counts secondary PLL input clocks
  logic pll2_in_tick;
  logic [7:0] frac_cnt_r;
  logic [7:0] frac_cnt_nxt;
  logic [12:0] fb_eff_r;
  logic [12:0] fb_eff_nxt;

  assign pll2_in_tick = src_core_r ? (on_pll && core_tick_i) : 1'b1;

  always_comb begin
    frac_cnt_nxt = frac_cnt_r;
    fb_eff_nxt = pll2_cfg_r.fb_div;
    if (frac_r.en) begin
      if (pll2_in_tick) begin
        frac_cnt_nxt = (frac_cnt_r >= frac_r.period) ? 8'h00 : frac_cnt_r + 8'h01;
      end
      // Settings with fraction not below period give fb_div + 1 on every cycle
      if (frac_cnt_r <= frac_r.fraction) begin
        fb_eff_nxt = pll2_cfg_r.fb_div + 13'h0001;
      end
    end else begin
      frac_cnt_nxt = 8'h00;
    end
  end

  always_ff @(posedge clk_i or negedge rstn) begin
    if (!rstn) begin
      frac_cnt_r <= 8'h00;
      fb_eff_r <= clk_gen_pkg::CORE_FB_RST;
    end else begin
      frac_cnt_r <= frac_cnt_nxt;
      fb_eff_r <= fb_eff_nxt;
    end
  end
  assign pll2_fb_eff_o = fb_eff_r;

  // Application clock: toggle every (app_div + 1) ticks, so period is even
  logic app_half;
  logic app_clk_r;
  logic app_clk_nxt;

  tick_div u_app_div (
    .clk_i(clk_i),
    .rstn_i(rstn),
    .tick_i(pll2_tick_i && lock2_s2_r && app_en_i),
    .div_i(app_div_i),
    .tick_o(app_half)
  );

  always_comb begin
    app_clk_nxt = app_clk_r;
    if (!app_en_i) begin
      app_clk_nxt = 1'b0;
    end else if (app_half) begin
      app_clk_nxt = !app_clk_r;
    end
  end

  // Soft reset: counted low pulse; PLL state above is untouched
  logic [3:0] srst_cnt_r;
  logic [3:0] srst_cnt_nxt;

  always_comb begin
    srst_cnt_nxt = srst_cnt_r;
    if (soft_rst_req_i) begin
      srst_cnt_nxt = clk_gen_pkg::SOFT_RST_CNT;
    end else if (srst_cnt_r != 4'h0) begin
      srst_cnt_nxt = srst_cnt_r - 4'h1;
    end
  end

  always_ff @(posedge clk_i or negedge rstn) begin
    if (!rstn) begin
      app_clk_r <= 1'b0;
      srst_cnt_r <= 4'h0;
    end else begin
      app_clk_r <= app_clk_nxt;
      srst_cnt_r <= srst_cnt_nxt;
    end
  end

  assign app_clock_out_pin_o = app_clk_r;
  assign tile1_clock_port_o = app_clk_r;
  assign soft_rstn_o = rstn && (srst_cnt_r == 4'h0);

endmodule
`default_nettype wire

// >>> verification/clk_gen_ctrl_sva.sv
// Port assertions for clk_gen_ctrl.
// Bound to every instance; sees only that instance's ports.
`timescale 1ns/10ps
`default_nettype none
module clk_gen_ctrl_sva (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // Inputs
  input wire logic core_cfg_wr_i,
  input wire clk_gen_pkg::pll_cfg_t core_cfg_i,
  input wire logic pll2_cfg_wr_i,
  input wire clk_gen_pkg::pll_cfg_t pll2_cfg_i,
  input wire logic low_power_i,
  input wire logic soft_rst_req_i,
  input wire logic core_tick_i,
  input wire logic app_en_i,
  // Outputs
  input wire clk_gen_pkg::pll_cfg_t core_cfg_o,
  input wire clk_gen_pkg::pll_cfg_t pll2_cfg_o,
  input wire logic on_pll_o,
  input wire logic pll_lowpower_o,
  input wire logic tile_ce_o,
  input wire logic ref_ce_o,
  input wire logic app_clock_out_pin_o,
  input wire logic tile1_clock_port_o,
  input wire logic soft_rstn_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  // Soft reset holds its output low for ten cycles
  sequence s_held_low;
    !soft_rstn_o [*8] ##1 !soft_rstn_o [*2];
  endsequence
  a_core_load: assert property (core_cfg_wr_i |=> core_cfg_o == $past(core_cfg_i))
    else $error("core settings not loaded");
  a_core_hold: assert property (!core_cfg_wr_i |=> $stable(core_cfg_o))
    else $error("core settings moved");
  a_pll2_load: assert property (pll2_cfg_wr_i |=> pll2_cfg_o == $past(pll2_cfg_i))
    else $error("secondary settings not loaded");
  a_write_parks: assert property (core_cfg_wr_i && !low_power_i |=> !on_pll_o [*2])
    else $error("stayed on PLL during rewrite");
  a_lowpwr_entry: assert property (low_power_i |=> pll_lowpower_o && !on_pll_o)
    else $error("low power not entered");
  a_relock_tick: assert property ($rose(on_pll_o) |-> $past(core_tick_i))
    else $error("switch back off a tick");
  a_ce_gated: assert property (on_pll_o && !core_tick_i |-> !tile_ce_o && !ref_ce_o)
    else $error("enable without PLL tick");
  a_app_off: assert property (!app_en_i |=> !app_clock_out_pin_o)
    else $error("app clock while disabled");
  a_pin_port: assert property (app_clock_out_pin_o == tile1_clock_port_o)
    else $error("pin and port differ");
  a_soft_width: assert property (soft_rst_req_i |=> s_held_low ##1 soft_rstn_o)
    else $error("soft reset width wrong");
endmodule
bind clk_gen_ctrl clk_gen_ctrl_sva u_clk_gen_ctrl_sva (.clk_i, .rstn_i, .core_cfg_wr_i,
  .core_cfg_i, .pll2_cfg_wr_i, .pll2_cfg_i, .low_power_i, .soft_rst_req_i, .core_tick_i,
  .app_en_i, .core_cfg_o, .pll2_cfg_o, .on_pll_o, .pll_lowpower_o, .tile_ce_o, .ref_ce_o,
  .app_clock_out_pin_o, .tile1_clock_port_o, .soft_rstn_o);
`default_nettype wire

// >>> verification/pll_osc_model.sv
// Stand-in for both PLL macros fed by a running oscillator.
// Lock drops on new core settings or in low power, then returns.
`timescale 1ns/10ps
`default_nettype none
module pll_osc_model (
  // Clock
  input wire logic clk_i,
  // From the control block
  input wire logic lowpower_i,
  input wire clk_gen_pkg::pll_cfg_t core_cfg_i,
  // To the control block
  output logic core_tick_o,
  output logic pll2_tick_o,
  output logic core_lock_o,
  output logic pll2_lock_o
);
  logic [3:0] lock_cnt_r = 4'h0;
  logic ph_r = 1'h0;
  clk_gen_pkg::pll_cfg_t cfg_r = '0;
  // Oscillator runs from time zero, before reset is let go
  always @(posedge clk_i) begin
    cfg_r <= core_cfg_i;
    ph_r <= ~ph_r;
    if (lowpower_i || cfg_r !== core_cfg_i) begin
      lock_cnt_r <= 4'h0;
    end else if (lock_cnt_r != 4'hF) begin
      lock_cnt_r <= lock_cnt_r + 4'h1;
    end
  end
  assign core_lock_o = lock_cnt_r > 4'h7;
  assign pll2_lock_o = core_lock_o;
  // Core output at half the oscillator rate, silent in low power
  assign core_tick_o = ph_r & ~lowpower_i;
  assign pll2_tick_o = ~lowpower_i;
endmodule
`default_nettype wire

// >>> verification/test_clk_gen_ctrl.sv
// Self-checking bench for clk_gen_ctrl with the PLL stand-in.
// Expected counts come from the divider and fraction formulas.
`timescale 1ns/10ps
`default_nettype none
module test_clk_gen_ctrl;
  logic clk_i = 1'h0;
  logic rstn_i = 1'h0;
  logic core_cfg_wr_i = 1'h0, pll2_cfg_wr_i = 1'h0, pll2_src_core_i = 1'h0, app_en_i = 1'h0;
  logic low_power_i = 1'h0, soft_rst_req_i = 1'h0;
  logic [7:0] app_div_i = 8'h00, tile_div_i = 8'h03, switch_div_i = 8'h01, ref_div_i = 8'h00;
  clk_gen_pkg::pll_cfg_t core_cfg_i = '0, pll2_cfg_i = '0, core_cfg_o, pll2_cfg_o, want;
  clk_gen_pkg::frac_cfg_t frac_cfg_i = '0;
  logic core_tick_i, pll2_tick_i, core_lock_i, pll2_lock_i, pll2_src_core_o, pll_lowpower_o;
  logic tile_ce_o, switch_ce_o, ref_ce_o, app_clock_out_pin_o, tile1_clock_port_o, on_pll_o;
  logic soft_rstn_o, last;
  logic [12:0] pll2_fb_eff_o;
  int err_total = 0, check_count = 0, n, t, d, p, f;
  int cnt [3];
  always #50 clk_i = ~clk_i;
  clk_gen_ctrl u_clk_gen_ctrl (.clk_i, .rstn_i, .core_cfg_wr_i, .core_cfg_i, .pll2_cfg_wr_i,
    .pll2_cfg_i, .pll2_src_core_i, .frac_cfg_i, .app_en_i, .app_div_i, .tile_div_i,
    .switch_div_i, .ref_div_i, .low_power_i, .soft_rst_req_i, .core_tick_i, .pll2_tick_i,
    .core_lock_i, .pll2_lock_i, .core_cfg_o, .pll2_cfg_o, .pll2_fb_eff_o, .pll2_src_core_o,
    .pll_lowpower_o, .tile_ce_o, .switch_ce_o, .ref_ce_o, .app_clock_out_pin_o,
    .tile1_clock_port_o, .on_pll_o, .soft_rstn_o);
  pll_osc_model u_pll_osc_model (.clk_i, .lowpower_i(pll_lowpower_o), .core_cfg_i(core_cfg_o),
    .core_tick_o(core_tick_i), .pll2_tick_o(pll2_tick_i), .core_lock_o(core_lock_i),
    .pll2_lock_o(pll2_lock_i));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  // Divider phase at window start is unknown, so allow one enable either way
  function automatic bit near(int ticks, int div, int seen);
    return (ticks / (div + 1) - seen) inside {[-1:1]};
  endfunction
  task automatic wait_pll();
    n = 0;
    while (on_pll_o !== 1'h1 && n < 200) begin
      @(negedge clk_i);
      n++;
    end
    check(on_pll_o, 1'h1);
  endtask
  task automatic core_wr(input clk_gen_pkg::pll_cfg_t c);
    @(posedge clk_i);
    core_cfg_i <= c;
    core_cfg_wr_i <= 1'h1;
    @(posedge clk_i);
    core_cfg_wr_i <= 1'h0;
    @(negedge clk_i);
  endtask
  task automatic pll2_wr(input logic s, input clk_gen_pkg::pll_cfg_t c,
                         input clk_gen_pkg::frac_cfg_t fr);
    @(posedge clk_i);
    pll2_src_core_i <= s;
    pll2_cfg_i <= c;
    frac_cfg_i <= fr;
    pll2_cfg_wr_i <= 1'h1;
    @(posedge clk_i);
    pll2_cfg_wr_i <= 1'h0;
    @(negedge clk_i);
  endtask
  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    #200000;
    err_total++;
    complete_run();
  end
  initial begin
    void'($urandom(11));
    repeat (2) @(posedge clk_i);
    rstn_i <= 1'h1;
    repeat (3) @(negedge clk_i);
    check(core_cfg_o, clk_gen_pkg::CORE_CFG_RST);
    wait_pll();
    repeat (2) begin
      // Random settings stay inside the legal divider ranges
      want = '{3'($urandom_range(7)), 13'($urandom_range(8191, 1)), 6'($urandom_range(63))};
      core_wr(want);
      check(core_cfg_o, want);
      wait_pll();
      @(posedge clk_i);
      tile_div_i <= 8'($urandom_range(7));
      switch_div_i <= 8'($urandom_range(7));
      cnt = '{0, 0, 0};
      t = 0;
      repeat (96) begin
        @(negedge clk_i);
        t += core_tick_i;
        cnt[0] += tile_ce_o;
        cnt[1] += switch_ce_o;
        cnt[2] += ref_ce_o;
      end
      check(near(t, tile_div_i, cnt[0]), 1'h1);
      check(near(t, switch_div_i, cnt[1]), 1'h1);
      check(near(t, ref_div_i, cnt[2]), 1'h1);
    end
    p = $urandom_range(7, 1);
    f = $urandom_range(p - 1);
    // Fraction kept below period
    pll2_wr(1'h0, '{3'h1, 13'h0100, 6'h01}, '{1'h1, 8'(p), 8'(f)});
    check(pll2_cfg_o, {3'h1, 13'h0100, 6'h01});
    check(pll2_src_core_o, 1'h0);
    repeat (4) @(negedge clk_i);
    n = 0;
    repeat (8 * (p + 1)) begin
      @(negedge clk_i);
      n += (pll2_fb_eff_o === 13'h0101);
    end
    check(n, 8 * (f + 1));
    pll2_wr(1'h1, '{3'h1, 13'h0100, 6'h01}, clk_gen_pkg::FRAC_CFG_RST);
    check(pll2_src_core_o, 1'h1);
    @(negedge clk_i);
    check(pll2_fb_eff_o, 13'h0100);
    d = $urandom_range(3);
    @(posedge clk_i);
    app_div_i <= 8'(d);
    app_en_i <= 1'h1;
    repeat (8) @(negedge clk_i);
    n = 0;
    last = app_clock_out_pin_o;
    repeat (20 * (d + 1)) begin
      @(negedge clk_i);
      n += (app_clock_out_pin_o !== last);
      last = app_clock_out_pin_o;
    end
    check(n, 20);
    @(posedge clk_i);
    app_en_i <= 1'h0;
    tile_div_i <= 8'h07;
    low_power_i <= 1'h1;
    repeat (2) @(negedge clk_i);
    check(pll_lowpower_o, 1'h1);
    check(app_clock_out_pin_o, 1'h0);
    @(posedge clk_i);
    low_power_i <= 1'h0;
    wait_pll();
    @(posedge clk_i);
    soft_rst_req_i <= 1'h1;
    @(posedge clk_i);
    soft_rst_req_i <= 1'h0;
    n = 0;
    repeat (14) begin
      @(negedge clk_i);
      n += (soft_rstn_o === 1'h0);
    end
    check(n, 10);
    check(core_cfg_o, want);
    complete_run();
  end
endmodule
`default_nettype wire
